// *** mccs_pkg.sv ***
// mccs_pkg: constants and types of the machine-cycle sequencer.
// assumes one oscillator clock drives the core and its internal bus.
package mccs_pkg;

  // ---------------------------------------------------------------
  // machine cycle shape
  // ---------------------------------------------------------------
  localparam int unsigned STATES_PER_CYCLE = 6;  // s1..s6
  localparam int unsigned PHASES_PER_STATE = 2;  // phase 1 / phase 2
  localparam int unsigned TICKS_PER_CYCLE  =
    STATES_PER_CYCLE * PHASES_PER_STATE;         // 12 osc periods
  localparam int unsigned TICK_W = 4;            // holds 0..11

  // tick index of a state/phase: (state-1)*2 + (phase-1)
  function automatic logic [TICK_W-1:0] tick_of(int unsigned st,
                                                int unsigned ph);
    tick_of = TICK_W'((st - 1) * PHASES_PER_STATE + (ph - 1));
  endfunction

  localparam logic [TICK_W-1:0] TICK_LAST  = tick_of(6, 2);
  // code fetch slots: address latch in phase 1, strobe in phase 2
  localparam logic [TICK_W-1:0] F1_LATCH   = tick_of(1, 1);
  localparam logic [TICK_W-1:0] F1_STROBE  = tick_of(1, 2);
  localparam logic [TICK_W-1:0] F2_LATCH   = tick_of(4, 1);
  localparam logic [TICK_W-1:0] F2_STROBE  = tick_of(4, 2);
  // external data cycle: latch in s1p1, strobe s3p1..s5p2
  localparam logic [TICK_W-1:0] X_LATCH    = tick_of(1, 1);
  localparam logic [TICK_W-1:0] X_STB_FROM = tick_of(3, 1);
  localparam logic [TICK_W-1:0] X_STB_TO   = tick_of(5, 2);

  // ---------------------------------------------------------------
  // instruction bytes and cycles
  // ---------------------------------------------------------------
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [1:0] CYC_ONE   = 2'h1;

  // ---------------------------------------------------------------
  // special register space
  // ---------------------------------------------------------------
  localparam logic [7:0] SREG_BASE   = 8'h80;
  // one bit per address 0x80..0xff, set where a register exists
  localparam logic [127:0] SREG_IMPL_MASK =
    128'h0001ffc3f0053f01019f4dff0ffb3f8f;
  localparam logic [2:0] SREG_ROW_HEAD = 3'h0;  // bit-addressable col

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MCCS_STG_FIRST = 2'b00,   // first machine cycle of instruction
    MCCS_STG_MORE  = 2'b01,   // later cycle, code fetches continue
    MCCS_STG_XDATA = 2'b10    // external data cycle, no fetch
  } mccs_stage_e;

  typedef enum logic [2:0] {
    MCCS_BR_NONE   = 3'b000,
    MCCS_BR_ACC_Z  = 3'b001,  // branch_if_acc_zero
    MCCS_BR_ACC_NZ = 3'b010,  // branch_if_acc_nonzero
    MCCS_BR_DEC_NZ = 3'b011,  // decrement_branch_nonzero
    MCCS_BR_CMP_NE = 3'b100   // compare_branch_unequal
  } mccs_branch_e;

endpackage

// *** mccs_branch_unit.sv ***
// mccs_branch_unit: combinational evaluation of conditional branches.
// assumes operands are stable in the cycle that execution completes.
`timescale 1ns/1ps
module mccs_branch_unit (
  input  wire mccs_pkg::mccs_branch_e kind,      // branch flavour
  input  wire logic [7:0]             acc,       // accumulator
  input  wire logic [7:0]             src_byte,  // direct/register
  input  wire logic [7:0]             cmp_byte,  // second compare op
  input  wire logic [7:0]             offset,    // signed rel byte
  input  wire logic [15:0]            next_pc,   // after the branch
  output logic                        take,      // branch taken
  output logic [15:0]                 target,    // destination
  output logic                        carry_we,  // carry is written
  output logic                        carry_val, // new carry
  output logic                        dec_we,    // decremented byte
  output logic [7:0]                  dec_val    // value written
);

  // ---------------------------------------------------------------
  // condition evaluation
  // ---------------------------------------------------------------
  logic [7:0] dec_byte;  // operand minus one, wraps at zero

  // sign-extend once and add; wrap at 64k like the pc itself
  assign target = next_pc + {{8{offset[7]}}, offset};
  assign dec_byte = src_byte - 8'h01;

  // one case per flavour; no zero flag exists so acc is tested
  always_comb begin
    take      = 1'b0;
    carry_we  = 1'b0;
    carry_val = 1'b0;
    dec_we    = 1'b0;
    dec_val   = dec_byte;
    case (kind)
      mccs_pkg::MCCS_BR_ACC_Z: begin
        take = (acc == 8'h00);
      end
      mccs_pkg::MCCS_BR_ACC_NZ: begin
        take = (acc != 8'h00);
      end
      mccs_pkg::MCCS_BR_DEC_NZ: begin
        dec_we = 1'b1;
        take   = (dec_byte != 8'h00);
      end
      mccs_pkg::MCCS_BR_CMP_NE: begin
        take      = (src_byte != cmp_byte);
        carry_we  = 1'b1;
        carry_val = (src_byte < cmp_byte);
      end
      default: begin
        take = 1'b0;
      end
    endcase
  end

endmodule

// *** mccs_core_sequencer.sv ***
// mccs_core_sequencer: machine-cycle timing of the 8-bit core, code
// fetches and external data moves on the internal bus, branch
// completion and special register write gating.
// assumes the memory_logic_module and the opcode decoder run on
// ref_clk and answer combinationally within one oscillator period.
//
// Contract
// - six two-period states make one machine cycle
// - every state has phase one and phase two
// - two code fetches in every machine cycle but a move's second
// - surplus fetched byte dropped, pc held
// - opcode latched into instruction register in s1
// - second fetch s4, execution ends after s6
// - external data move: two cycles, second fetchless
// - fetches skipped only in that second cycle
// - decrement-and-branch taken when result nonzero
// - internal bus: address, data, five strobes
// - writes to unimplemented special registers ignored
// - row heads 0x80..0xf8 are bit-addressable
// - compare branch taken when operands differ
// - compare sets carry when first is smaller
// - accumulator branches test accumulator directly
// - signed offset added to following address
`timescale 1ns/1ps
module mccs_core_sequencer #(
  parameter int unsigned ADDR_W = 16,  // internal address width
  parameter int unsigned DATA_W = 8    // internal data width
) (
  input  wire logic                   ref_clk,      // oscillator
  input  wire logic                   rst_n,        // async reset
  // decoder answers for the opcode held in instr_reg
  input  wire logic [1:0]             dec_len,      // bytes 1..3
  input  wire logic [1:0]             dec_cycles,   // cycles 1..2
  input  wire logic                   dec_xmove,    // ext data move
  input  wire logic                   dec_xwrite,   // move is a write
  input  wire mccs_pkg::mccs_branch_e dec_branch,   // branch flavour
  // datapath operands
  input  wire logic [7:0]             acc,          // accumulator
  input  wire logic [7:0]             src_byte,     // branch operand
  input  wire logic [7:0]             cmp_byte,     // compare operand
  input  wire logic [15:0]            xdata_addr,   // move address
  input  wire logic [7:0]             xdata_wdata,  // move write data
  // internal bus to the memory_logic_module
  output logic [15:0]                 bus_addr,     // a0..a15
  output logic [7:0]                  bus_wdata,    // d0..d7 out
  output logic                        bus_wdata_oe, // d0..d7 driven
  input  wire logic [7:0]             bus_rdata,    // d0..d7 in
  output logic                        bus_rd_n,     // data read
  output logic                        bus_wr_n,     // data write
  output logic                        program_store_strobe_n,
  output logic                        bus_ale,      // address latch
  output logic                        bus_reset_n,  // module reset
  // sequencer status
  output logic [3:0]                  seq_state,    // 1..6
  output logic                        seq_phase2,   // second half
  output logic [7:0]                  instr_reg,    // opcode
  output logic [15:0]                 prog_counter, // pc
  output logic                        exec_done,    // end pulse
  output logic                        branch_taken, // with exec_done
  output logic [7:0]                  xdata_rdata,  // move read data
  output logic                        wb_dec_en,    // write wb_dec
  output logic [7:0]                  wb_dec,       // decremented
  output logic                        carry_en,     // write carry
  output logic                        carry_val,    // new carry
  // special_register_space access from the datapath
  input  wire logic                   sreg_wr_req,  // write request
  input  wire logic [7:0]             sreg_addr,    // byte address
  input  wire logic [7:0]             sreg_rd_in,   // register data
  output logic                        sreg_wr_en,   // gated write
  output logic                        sreg_bit_ok,  // bit access ok
  output logic [7:0]                  sreg_rd_data  // read answer
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // the fetch counter and bus widths are fixed by the core
  if (ADDR_W != 16 || DATA_W != 8) begin : g_width_check
    $error("mccs_core_sequencer supports 16-bit address, 8-bit data");
  end

  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [mccs_pkg::TICK_W-1:0] tick;      // oscillator period 0..11
    mccs_pkg::mccs_stage_e       stage;     // cycle kind
    logic [1:0]                  mcyc;      // cycle within instr
    logic [1:0]                  byte_idx;  // bytes consumed
    logic [7:0]                  ir;        // opcode
    logic [7:0]                  opnd1;     // second code byte
    logic [7:0]                  opnd2;     // third code byte
    logic [15:0]                 pc;        // program counter
    logic [15:0]                 addr;      // address on the bus
    logic [7:0]                  wdata;     // move write data
    logic [7:0]                  rdata;     // move read data
    logic                        xwr;       // move direction held
    logic                        done;      // exec_done pulse
    logic                        taken;     // branch taken pulse
    logic                        dec_en;    // write-back strobe
    logic [7:0]                  dec;       // write-back value
    logic                        cy_en;     // carry strobe
    logic                        cy;        // carry value
    logic                        rst_out_n; // module reset release
  } mccs_seq_s;

  mccs_seq_s s;       // registered state
  mccs_seq_s next_s;  // value for the next edge

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // capture edge of a code fetch slot; never in the data cycle
  function automatic logic is_fetch_strobe(
    logic [mccs_pkg::TICK_W-1:0] t, mccs_pkg::mccs_stage_e st);
    is_fetch_strobe = (st != mccs_pkg::MCCS_STG_XDATA) &&
                      (t == mccs_pkg::F1_STROBE ||
                       t == mccs_pkg::F2_STROBE);
  endfunction

  // address latch slot of a code fetch
  function automatic logic is_fetch_latch(
    logic [mccs_pkg::TICK_W-1:0] t, mccs_pkg::mccs_stage_e st);
    is_fetch_latch = (st != mccs_pkg::MCCS_STG_XDATA) &&
                     (t == mccs_pkg::F1_LATCH ||
                      t == mccs_pkg::F2_LATCH);
  endfunction

  // true when a special register exists at the address
  function automatic logic sreg_implemented(logic [7:0] a);
    sreg_implemented = a[7] &&
      mccs_pkg::SREG_IMPL_MASK[7'(a - mccs_pkg::SREG_BASE)];
  endfunction

  // ---------------------------------------------------------------
  // branch evaluation
  // ---------------------------------------------------------------
  logic        br_take;      // condition met
  logic [15:0] br_target;    // pc of destination
  logic        br_carry_we;  // compare writes carry
  logic        br_carry;     // compare result
  logic        br_dec_we;    // decrement writes back
  logic [7:0]  br_dec;       // decremented operand
  logic [7:0]  br_offset;    // relative byte, always the last one

  assign br_offset = (dec_len == mccs_pkg::LEN_THREE) ? s.opnd2
                                                      : s.opnd1;

  // pc already points past the last byte when execution ends
  mccs_branch_unit u_branch (
    .kind      (dec_branch),
    .acc       (acc),
    .src_byte  (src_byte),
    .cmp_byte  (cmp_byte),
    .offset    (br_offset),
    .next_pc   (s.pc),
    .take      (br_take),
    .target    (br_target),
    .carry_we  (br_carry_we),
    .carry_val (br_carry),
    .dec_we    (br_dec_we),
    .dec_val   (br_dec)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  logic last_tick;  // end of s6 phase 2
  logic finish;     // instruction completes this edge

  // walks the twelve periods and the fetch/execute slots
  always_comb begin
    next_s           = s;
    next_s.done      = 1'b0;
    next_s.taken     = 1'b0;
    next_s.dec_en    = 1'b0;
    next_s.cy_en     = 1'b0;
    next_s.rst_out_n = 1'b1;
    last_tick        = (s.tick == mccs_pkg::TICK_LAST);
    finish           = 1'b0;

    // twelve periods, two per state
    if (last_tick) begin
      next_s.tick = '0;
    end else begin
      next_s.tick = s.tick + 1'b1;
    end

    // code byte arrives at the end of a strobe phase
    if (is_fetch_strobe(s.tick, s.stage)) begin
      if (s.stage == mccs_pkg::MCCS_STG_FIRST &&
          s.mcyc == 2'h0 && s.tick == mccs_pkg::F1_STROBE) begin
        next_s.ir       = bus_rdata;
        next_s.pc       = s.pc + 16'h0001;
        next_s.byte_idx = 2'h1;
      end else if (s.byte_idx < dec_len) begin
        if (s.byte_idx == mccs_pkg::LEN_ONE) begin
          next_s.opnd1 = bus_rdata;
        end else begin
          next_s.opnd2 = bus_rdata;
        end
        next_s.pc       = s.pc + 16'h0001;
        next_s.byte_idx = s.byte_idx + 2'h1;
      end
      // otherwise the byte is surplus: dropped, pc held
    end

    // external data cycle: hold direction and data, catch reads
    if (s.stage == mccs_pkg::MCCS_STG_XDATA) begin
      if (s.tick == mccs_pkg::X_LATCH) begin
        next_s.wdata = xdata_wdata;
        next_s.xwr   = dec_xwrite;
      end
      if (s.tick == mccs_pkg::X_STB_TO && !s.xwr) begin
        next_s.rdata = bus_rdata;
      end
    end

    // machine cycle boundary
    if (last_tick) begin
      if (s.mcyc + 2'h1 < dec_cycles) begin
        next_s.mcyc = s.mcyc + 2'h1;
        // only the move's second cycle skips fetching
        next_s.stage = dec_xmove ? mccs_pkg::MCCS_STG_XDATA
                                 : mccs_pkg::MCCS_STG_MORE;
      end else begin
        finish = 1'b1;  // ends with s6 of the last cycle
      end
    end

    // retire the instruction and resolve any branch
    if (finish) begin
      next_s.done     = 1'b1;
      next_s.mcyc     = 2'h0;
      next_s.byte_idx = 2'h0;
      next_s.stage    = mccs_pkg::MCCS_STG_FIRST;
      next_s.dec_en   = br_dec_we;
      next_s.dec      = br_dec;
      next_s.cy_en    = br_carry_we;
      next_s.cy       = br_carry;
      if (br_take) begin
        next_s.taken = 1'b1;
        next_s.pc    = br_target;
      end
    end

    // bus address is registered: move address or next code byte
    if (next_s.stage == mccs_pkg::MCCS_STG_XDATA) begin
      next_s.addr = (s.stage == mccs_pkg::MCCS_STG_XDATA) ? s.addr
                                                         : xdata_addr;
    end else begin
      next_s.addr = next_s.pc;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // reset lands on s1 phase 1 of a fresh cycle, first fetch slot
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // internal bus strobes
  // ---------------------------------------------------------------
  logic x_cycle;   // data cycle in progress
  logic x_window;  // data strobe window s3p1..s5p2

  assign x_cycle  = (s.stage == mccs_pkg::MCCS_STG_XDATA);
  assign x_window = x_cycle && s.tick >= mccs_pkg::X_STB_FROM &&
                    s.tick <= mccs_pkg::X_STB_TO;

  // strobes decode the registered tick, so they are glitch-limited
  // to one gate level; the module samples them on ref_clk anyway
  assign bus_ale = is_fetch_latch(s.tick, s.stage) ||
                   (x_cycle && s.tick == mccs_pkg::X_LATCH);
  assign program_store_strobe_n = !is_fetch_strobe(s.tick, s.stage);
  assign bus_rd_n     = !(x_window && !s.xwr);
  assign bus_wr_n     = !(x_window && s.xwr);
  assign bus_wdata_oe = x_window && s.xwr;
  assign bus_wdata    = s.wdata;
  assign bus_addr     = s.addr;
  assign bus_reset_n  = s.rst_out_n;

  // ---------------------------------------------------------------
  // status outputs
  // ---------------------------------------------------------------
  assign seq_state    = 4'((s.tick >> 1) + 1'b1);
  assign seq_phase2   = s.tick[0];
  assign instr_reg    = s.ir;
  assign prog_counter = s.pc;
  assign exec_done    = s.done;
  assign branch_taken = s.taken;
  assign xdata_rdata  = s.rdata;
  assign wb_dec_en    = s.dec_en;
  assign wb_dec       = s.dec;
  assign carry_en     = s.cy_en;
  assign carry_val    = s.cy;

  // ---------------------------------------------------------------
  // special register space
  // ---------------------------------------------------------------
  // holes swallow writes; reads of holes give zero, which is one
  // legal choice of undefined data and keeps simulation clean
  assign sreg_wr_en   = sreg_wr_req &&
                        sreg_implemented(sreg_addr);
  assign sreg_rd_data = sreg_implemented(sreg_addr) ? sreg_rd_in
                                                    : 8'h00;
  assign sreg_bit_ok  = sreg_addr[7] &&
    (sreg_addr[2:0] == mccs_pkg::SREG_ROW_HEAD);

endmodule

// *** mccs_chk.sv ***
// mccs_chk: port-level timing checks of the cycle sequencer.
// assumes one clock domain and an async active-low reset.
`timescale 1ns/1ps
module mccs_chk (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic [3:0] seq_state,
  input wire logic       seq_phase2,
  input wire logic       program_store_strobe_n,
  input wire logic       bus_rd_n,
  input wire logic       bus_wr_n,
  input wire logic       exec_done,
  input wire logic       sreg_wr_req,
  input wire logic [7:0] sreg_addr,
  input wire logic       sreg_wr_en,
  input wire logic       sreg_bit_ok
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // code fetches seen in the current machine cycle
  // ------------------------------------------------------------
  logic [1:0] n_fetch;  // code strobes so far
  logic       saw_data; // a data strobe came
  // cleared at s1p1, where no strobe may sit, so no strobe is lost
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      n_fetch  <= 2'h0;
      saw_data <= 1'b0;
    end else if (seq_state == 4'h1 && !seq_phase2) begin
      n_fetch  <= 2'h0;
      saw_data <= 1'b0;
    end else begin
      n_fetch  <= n_fetch + {1'b0, !program_store_strobe_n};
      saw_data <= saw_data | !bus_rd_n | !bus_wr_n;
    end
  end
  property p_phase_hold;
    !seq_phase2 |=> seq_phase2 && $stable(seq_state);
  endproperty
  a_phase_hold: assert property (p_phase_hold)
    else $error("state left before its second phase");
  property p_state_step;
    seq_phase2 |=> !seq_phase2 && seq_state ==
      (($past(seq_state) == 4'h6) ? 4'h1 : $past(seq_state) + 4'h1);
  endproperty
  a_state_step: assert property (p_state_step)
    else $error("state did not step 1 to 6 and wrap");
  property p_fetch_slot;
    !program_store_strobe_n |-> seq_phase2 &&
      (seq_state == 4'h1 || seq_state == 4'h4);
  endproperty
  a_fetch_slot: assert property (p_fetch_slot)
    else $error("code strobe outside s1p2 and s4p2");
  property p_fetch_count;
    seq_state == 4'h6 && seq_phase2 |-> n_fetch == (saw_data ? 2'h0 : 2'h2);
  endproperty
  a_fetch_count: assert property (p_fetch_count)
    else $error("wrong number of code fetches in a cycle");
  property p_data_window;
    !bus_rd_n || !bus_wr_n |-> seq_state inside {[4'h3:4'h5]} &&
      program_store_strobe_n && (bus_rd_n || bus_wr_n);
  endproperty
  a_data_window: assert property (p_data_window)
    else $error("data strobe outside s3 to s5 or clashing");
  property p_done_slot;
    exec_done |-> seq_state == 4'h1 && !seq_phase2 ##1 !exec_done;
  endproperty
  a_done_slot: assert property (p_done_slot)
    else $error("end pulse not a single s1p1 pulse");
  property p_sreg_gate;
    sreg_wr_en == (sreg_wr_req && sreg_addr >= 8'h80 &&
      mccs_pkg::SREG_IMPL_MASK[sreg_addr[6:0]]);
  endproperty
  a_sreg_gate: assert property (p_sreg_gate)
    else $error("write reached an unimplemented register");
  property p_bit_ok;
    sreg_bit_ok == (sreg_addr >= 8'h80 && sreg_addr[2:0] == 3'h0);
  endproperty
  a_bit_ok: assert property (p_bit_ok)
    else $error("bit access flag wrong for address");
endmodule
bind mccs_core_sequencer mccs_chk u_chk (.*);

// *** mccs_mem_model.sv ***
// mccs_mem_model: memory_logic_module stand-in on the internal bus.
// assumes low strobes, answered in the same tick, no wait states.
`timescale 1ns/1ps
module mccs_mem_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wdata_oe,
  input  wire logic        bus_rd_n,
  input  wire logic        bus_wr_n,
  input  wire logic        program_store_strobe_n,
  output logic      [7:0]  bus_rdata
);
  logic [7:0] mem [256];      // low address byte only, keeps it small
  logic [7:0] last_q = 8'h00; // last byte put on the data lines
  // released lines show the inverse, so a late sample cannot pass
  always_comb begin
    if (!program_store_strobe_n || !bus_rd_n)
      bus_rdata = mem[bus_addr[7:0]];
    else
      bus_rdata = ~last_q;
  end
  // remember the answer and take data writes
  always @(posedge ref_clk) begin
    if (!program_store_strobe_n || !bus_rd_n)
      last_q <= bus_rdata;
    if (!bus_wr_n && bus_wdata_oe)
      mem[bus_addr[7:0]] <= bus_wdata;
  end
endmodule

// *** tb_top.sv ***
// tb_top: self-checking bench of the machine-cycle sequencer.
// assumes the bench plays the opcode decoder and the datapath.
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk = 1'b0, rst_n = 1'b0, sreg_wr_req = 1'b0;
  logic [1:0]  dec_len, dec_cycles;
  logic        dec_xmove, dec_xwrite;
  mccs_pkg::mccs_branch_e dec_branch;
  logic [7:0]  acc = 8'h00, src_byte = 8'h00, cmp_byte = 8'h00;
  logic [7:0]  xdata_wdata = 8'h00, sreg_addr = 8'h80, sreg_rd_in = 8'h00;
  logic [15:0] xdata_addr = 16'h0000, bus_addr, prog_counter;
  logic [7:0]  bus_wdata, bus_rdata, instr_reg, xdata_rdata, wb_dec;
  logic [7:0]  sreg_rd_data;
  logic [3:0]  seq_state;
  logic        bus_wdata_oe, bus_rd_n, bus_wr_n, program_store_strobe_n;
  logic        bus_ale, bus_reset_n, seq_phase2, exec_done, branch_taken;
  logic        wb_dec_en, carry_en, carry_val, sreg_wr_en, sreg_bit_ok;
  int          num_errors = 0, n_checks = 0;
  mccs_core_sequencer dut (.*);
  mccs_mem_model u_mem (.*);
  initial forever #2.5 ref_clk = ~ref_clk;
  // decoder: [1:0] length, [2] data move, [3] write, [6:4] branch
  always_comb begin
    dec_len    = (instr_reg[1:0] == 2'h0) ? 2'h1 : instr_reg[1:0];
    dec_xmove  = instr_reg[2];
    dec_xwrite = instr_reg[3];
    dec_cycles = (dec_xmove || dec_len == 2'h3) ? 2'h2 : 2'h1;
    dec_branch = mccs_pkg::mccs_branch_e'(instr_reg[6:4]);
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // bounded wait for the end pulse; n counts the negedges taken
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (exec_done !== 1'b1 && n < 60);
    if (exec_done !== 1'b1) begin
      num_errors++;
      results();
    end
  endtask
  // reset in mid-run, check the idle state, refill memory with 1-byte ops
  task automatic hold_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    check("rst state", 16'({seq_state, seq_phase2}), 16'h0002);
    check("rst pc", prog_counter, 16'h0000);
    check("rst bus",
          16'({bus_reset_n, program_store_strobe_n}), 16'h0001);
    for (int i = 0; i < 256; i++)
      u_mem.mem[i] = 8'h01;
  endtask
  // mixed lengths: opcode, pc and cycle spacing per instruction
  task automatic seq_test();
    int n;
    logic [31:0] tab [4] = '{32'h01_0001_0d, 32'h02_0003_0c,
                             32'h03_0006_18, 32'h01_0007_0c};
    hold_reset();
    u_mem.mem[1] = 8'h02;
    u_mem.mem[3] = 8'h03;
    rst_n <= 1'b1;
    foreach (tab[i]) begin
      wait_done(n);
      check("opcode", 16'(instr_reg), 16'(tab[i][31:24]));
      check("pc", prog_counter, tab[i][23:8]);
      check("ticks", 16'(n), 16'(tab[i][7:0]));
      check("run bus", 16'({bus_reset_n, bus_ale}), 16'h0003);
    end
    $display("test seq done");
  endtask
  // data move read or write: two cycles, no fetch in the second
  task automatic move_test(input logic wr);
    int n;
    hold_reset();
    u_mem.mem[0] = wr ? 8'h0d : 8'h05;
    u_mem.mem[8'h40] = 8'ha5;
    xdata_addr  <= 16'h0040;
    xdata_wdata <= 8'h5a;
    rst_n       <= 1'b1;
    wait_done(n);
    check("move ticks", 16'(n), 16'h0019);
    check("move pc", prog_counter, 16'h0001);
    if (wr)
      check("written", 16'(u_mem.mem[8'h40]), 16'h005a);
    else
      check("read", 16'(xdata_rdata), 16'h00a5);
    $display("test move done");
  endtask
  // every branch kind, taken and not (acc nonzero only taken), offsets at both limits
  task automatic branch_test();
    logic [7:0]  op, a, b, off;
    logic [15:0] tgt;
    int          n;
    logic [47:0] tab [7] = '{48'h12_00_00_7f_0081, 48'h12_01_00_7f_0002,
      48'h22_01_00_80_ff82, 48'h32_01_00_10_0002, 48'h32_00_00_10_0012,
      48'h42_03_05_fe_0000, 48'h42_05_05_fe_0002};
    foreach (tab[i]) begin
      {op, a, b, off, tgt} = tab[i];
      hold_reset();
      u_mem.mem[0] = op;
      u_mem.mem[1] = off;
      acc      <= a;
      src_byte <= a;
      cmp_byte <= b;
      rst_n    <= 1'b1;
      wait_done(n);
      check("target", prog_counter, tgt);
      check("taken", 16'(branch_taken), 16'(tgt != 16'h0002));
      if (op == 8'h32)
        check("dec", 16'({wb_dec_en, wb_dec}), {8'h01, a - 8'h01});
      if (op == 8'h42)
        check("carry", 16'({carry_en, carry_val}), {15'h1, a < b});
    end
    $display("test branch done");
  endtask
  // whole special register space: write gate, read answer, bit flag
  task automatic sreg_test();
    logic imp;
    // dataless writes: nothing nonzero reaches a hole
    sreg_wr_req <= 1'b1;
    sreg_rd_in  <= 8'h3c;
    for (int i = 128; i < 256; i++) begin
      @(posedge ref_clk);
      sreg_addr <= 8'(i);
      @(negedge ref_clk);
      imp = mccs_pkg::SREG_IMPL_MASK[i - 128];
      check("sreg wr", 16'(sreg_wr_en), 16'(imp));
      check("sreg rd", 16'(sreg_rd_data), 16'({8{imp}} & 8'h3c));
      check("bit ok", 16'(sreg_bit_ok), 16'(i[2:0] == 3'h0));
    end
    $display("test sreg done");
  endtask
  initial begin
    seq_test();
    move_test(1'b0);
    move_test(1'b1);
    branch_test();
    sreg_test();
    results();
  end
endmodule
